// File: hdl/slc_defs.svh
// register indices, field positions and reset values of the switch link configuration block
`ifndef SLC_DEFS_SVH
`define SLC_DEFS_SVH

// register indices; byte address is four times the index
`define SLC_IDX_SWCFG    8'h04
`define SLC_IDX_NODE     8'h05
`define SLC_IDX_DIR_LO   8'h0c
`define SLC_IDX_DIR_HI   8'h0d
`define SLC_IDX_LSTAT    8'h20
`define SLC_IDX_PSTAT    8'h40
`define SLC_IDX_LCFG     8'h80
`define SLC_IDX_STATIC   8'ha0
`define SLC_IDX_GROUP    8'hf8

// status register fields
`define SLC_B_STYPE_HI   25
`define SLC_B_STYPE_LO   24
`define SLC_B_DEST_HI    23
`define SLC_B_DEST_LO    16
`define SLC_B_DIR_HI     11
`define SLC_B_DIR_LO     8
`define SLC_B_NET_HI     5
`define SLC_B_NET_LO     4
`define SLC_B_JUNK       2
`define SLC_B_DBUSY      1
`define SLC_B_SBUSY      0

// link configuration fields
`define SLC_B_ENABLE     31
`define SLC_B_FIVE_WIRE  30
`define SLC_B_RX_FAULT   27
`define SLC_B_CR_GIVEN   26
`define SLC_B_CR_HELD    25
`define SLC_B_CREDIT_GREETING_TOKEN      24
`define SLC_B_RX_RESTART 23
`define SLC_B_SGAP_HI    21
`define SLC_B_SGAP_LO    11
`define SLC_B_TGAP_HI    10
`define SLC_B_TGAP_LO    0

// static forwarding fields
`define SLC_B_FWD_EN     31
`define SLC_B_FWD_PROC   8
`define SLC_B_FWD_CE_HI  4
`define SLC_B_FWD_CE_LO  0

// switch configuration fields
`define SLC_B_PROTECT    31
`define SLC_B_HDR_MODE   0

// reset values
`define SLC_RST_DIR      4'h0
`define SLC_RST_NET      2'h0
`define SLC_RST_GAP      11'h000
`define SLC_RST_NODE     16'h0000
`define SLC_RST_DIRS     32'h00000000
`define SLC_RST_FWD      7'h00

// bus answers
`define SLC_RESP_OKAY    2'h0
`define SLC_RESP_DECERR  2'h3

`endif

// File: hdl/slc_pkg.sv
// types shared by the switch link configuration block
package slc_pkg;
	typedef struct packed {
		logic [1:0] stype;
		logic [7:0] dest;
		logic       junk;
		logic       dest_busy;
		logic       src_busy;
	} slc_lnk_state_t;

	typedef struct packed {
		logic rx_fault;
		logic credit_given;
		logic credit_held;
	} slc_phy_state_t;

	typedef struct packed {
		logic       enable;
		logic       five_wire;
		logic [3:0] direction;
		logic [1:0] network;
	} slc_lnk_ctrl_t;

	typedef struct packed {
		logic       enable;
		logic       proc;
		logic [4:0] chanend;
	} slc_fwd_t;

	typedef enum logic [3:0] {
		SLC_R_NONE, SLC_R_SWCFG, SLC_R_NODE, SLC_R_DIRLO, SLC_R_DIRHI,
		SLC_R_LSTAT, SLC_R_PSTAT, SLC_R_LCFG, SLC_R_STATIC
	} slc_region_t;

	typedef struct packed {
		slc_region_t region;
		logic [2:0]  idx;
	} slc_sel_t;
endpackage

// File: hdl/slc_link_pacer.sv
// idle spacing between transmitted symbols and tokens of one external link
`timescale 1ns/1ps
module slc_link_pacer
	import slc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// programmed gaps
	input  wire logic [10:0] sym_gap,
	input  wire logic [10:0] tok_gap,
	// transmitter handshake
	input  wire logic        sym_valid,
	input  wire logic        sym_last,
	output logic             sym_ready
);
	logic [11:0] idle_cnt;
	logic        fire;

	assign sym_ready = (idle_cnt == 12'h000);
	assign fire      = sym_valid && sym_ready;

	// gap+1 idle clocks follow every symbol; the last symbol of a token uses the token gap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_cnt <= 12'h000;
		end else if (fire) begin
			idle_cnt <= (sym_last ? {1'b0, tok_gap} : {1'b0, sym_gap}) + 12'h001;
		end else if (idle_cnt != 12'h000) begin
			idle_cnt <= idle_cnt - 12'h001;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_symbol_gap_zero: assert property (fire && !sym_last && sym_gap == 11'h000 |=> !sym_ready ##1 sym_ready)
		else $error("symbol gap of one idle clock not kept");
	a_token_gap_two: assert property (fire && sym_last && tok_gap == 11'h002 |=> !sym_ready [*3] ##1 sym_ready)
		else $error("token gap of three idle clocks not kept");
	c_symbol_sent: cover property (fire && !sym_last);
endmodule // slc_link_pacer

// File: hdl/slc_switch_link_regs.sv
// switch link status, configuration and static forwarding registers on an AXI4-Lite slave
// Contract
// - status reports two-bit source-target type: switch link, processor link, control target.
// - status reports eight-bit destination link number while link in use.
// - link status holds writable four-bit direction field, reset zero.
// - link and processor-link status hold writable two-bit network number, reset zero.
// - read-only flag shows current packet judged junk and discarded.
// - read-only flags show destination side and source side in use.
// - status and configuration groups each have one register per link 0..7.
// - processor-link status omits direction; bits 15:6 reserved.
// - configuration top bit enables or disables external link and steers pin muxing.
// - wire-mode bit selects two-wire when zero, five-wire when one; resets zero.
// - read-only error flag on receive overflow or illegal token encoding.
// - read-only flag shows local end issued credit to remote end.
// - read-only flag shows local end holds credit to transmit.
// - writing credit_greeting_token bit clears local credit and sends greeting token.
// - writing receiver-reset bit restarts receiver at first symbol of token.
// - at least programmed value plus one idle clocks between symbols.
// - at least programmed value plus one idle clocks between tokens.
// - static forwarding enable bypasses routing to configured channel end; resets zero.
// - static mode forwards to one-bit processor and five-bit channel end.
// - static registers map ascending to links C, D, A, B, G, H, E, F.
// - write-protect bit set makes switch control register writes ignored.
// - foreign packets route by direction of most significant mismatching node bit.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "slc_defs.svh"
module slc_switch_link_regs
	import slc_pkg::*;
(
	// clock and reset
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// axi4-lite write channels
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read channels
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// switch core state per link
	input  wire slc_lnk_state_t [7:0] lnk_state,
	input  wire slc_lnk_state_t [7:0] plnk_state,
	input  wire slc_phy_state_t [7:0] phy_state,
	// link control
	output slc_lnk_ctrl_t [7:0]       lnk_ctrl,
	output logic [7:0][1:0]           plnk_network,
	output logic [7:0]                credit_greeting_token_strobe,
	output logic [7:0]                rx_restart,
	// transmit pacing
	input  wire logic [7:0]           tx_sym_valid,
	input  wire logic [7:0]           tx_sym_last,
	output logic [7:0]                tx_sym_ready,
	// static forwarding, indexed by link letter a..h
	output slc_fwd_t [7:0]            fwd_cfg,
	// routing lookup
	input  wire logic [15:0]          route_node_id,
	output logic [3:0]                route_dir,
	output logic                      route_local
);
	logic                  protect, hdr_mode;
	logic [15:0]           node_id;
	logic [31:0]           dir_lo, dir_hi;
	logic [7:0][3:0]       lnk_dir;
	logic [7:0][1:0]       lnk_net, plnk_net;
	logic [7:0]            lnk_en, lnk_five;
	logic [7:0][10:0]      sym_gap, tok_gap;
	logic [7:0]            rx_fault;
	slc_fwd_t [7:0]        fwd_reg;
	logic                  aw_held, w_held, wr_fire, wr_ok;
	logic [11:0]           awaddr_q;
	logic [31:0]           wdata_q, wmask, wd;
	logic [3:0]            wstrb_q;
	slc_sel_t              wsel, rsel;
	slc_region_t           rd_region;
	function automatic slc_sel_t slc_decode(input logic [11:0] a);
		slc_sel_t   s;
		logic [7:0] ix;
		ix       = a[9:2];
		s.idx    = ix[2:0];
		s.region = SLC_R_NONE;
		if (a[11:10] == 2'h0) begin
			if (ix == `SLC_IDX_SWCFG) s.region = SLC_R_SWCFG;
			else if (ix == `SLC_IDX_NODE) s.region = SLC_R_NODE;
			else if (ix == `SLC_IDX_DIR_LO) s.region = SLC_R_DIRLO;
			else if (ix == `SLC_IDX_DIR_HI) s.region = SLC_R_DIRHI;
			else if ((ix & `SLC_IDX_GROUP) == `SLC_IDX_LSTAT) s.region = SLC_R_LSTAT;
			else if ((ix & `SLC_IDX_GROUP) == `SLC_IDX_PSTAT) s.region = SLC_R_PSTAT;
			else if ((ix & `SLC_IDX_GROUP) == `SLC_IDX_LCFG) s.region = SLC_R_LCFG;
			else if ((ix & `SLC_IDX_GROUP) == `SLC_IDX_STATIC) s.region = SLC_R_STATIC;
		end
		return s;
	endfunction
	// current word of a register; reserved and write-only bits stay zero
	function automatic logic [31:0] slc_word(input slc_sel_t s);
		logic [31:0] w;
		w = 32'h00000000;
		case (s.region)
			SLC_R_SWCFG: begin
				w[`SLC_B_PROTECT]  = protect;
				w[`SLC_B_HDR_MODE] = hdr_mode;
			end
			SLC_R_NODE:  w[15:0] = node_id;
			SLC_R_DIRLO: w = dir_lo;
			SLC_R_DIRHI: w = dir_hi;
			SLC_R_LSTAT, SLC_R_PSTAT: begin
				if (s.region == SLC_R_LSTAT) begin
					w[`SLC_B_STYPE_HI:`SLC_B_STYPE_LO] = lnk_state[s.idx].stype;
					w[`SLC_B_DEST_HI:`SLC_B_DEST_LO]   = lnk_state[s.idx].dest;
					w[`SLC_B_DIR_HI:`SLC_B_DIR_LO]     = lnk_dir[s.idx];
					w[`SLC_B_NET_HI:`SLC_B_NET_LO]     = lnk_net[s.idx];
					w[`SLC_B_JUNK]                     = lnk_state[s.idx].junk;
					w[`SLC_B_DBUSY]                    = lnk_state[s.idx].dest_busy;
					w[`SLC_B_SBUSY]                    = lnk_state[s.idx].src_busy;
				end else begin
					w[`SLC_B_STYPE_HI:`SLC_B_STYPE_LO] = plnk_state[s.idx].stype;
					w[`SLC_B_DEST_HI:`SLC_B_DEST_LO]   = plnk_state[s.idx].dest;
					w[`SLC_B_NET_HI:`SLC_B_NET_LO]     = plnk_net[s.idx];
					w[`SLC_B_JUNK]                     = plnk_state[s.idx].junk;
					w[`SLC_B_DBUSY]                    = plnk_state[s.idx].dest_busy;
					w[`SLC_B_SBUSY]                    = plnk_state[s.idx].src_busy;
				end
			end
			SLC_R_LCFG: begin
				w[`SLC_B_ENABLE]                 = lnk_en[s.idx];
				w[`SLC_B_FIVE_WIRE]              = lnk_five[s.idx];
				w[`SLC_B_RX_FAULT]               = rx_fault[s.idx];
				w[`SLC_B_CR_GIVEN]               = phy_state[s.idx].credit_given;
				w[`SLC_B_CR_HELD]                = phy_state[s.idx].credit_held;
				w[`SLC_B_SGAP_HI:`SLC_B_SGAP_LO] = sym_gap[s.idx];
				w[`SLC_B_TGAP_HI:`SLC_B_TGAP_LO] = tok_gap[s.idx];
			end
			SLC_R_STATIC: begin
				w[`SLC_B_FWD_EN]                   = fwd_reg[s.idx].enable;
				w[`SLC_B_FWD_PROC]                 = fwd_reg[s.idx].proc;
				w[`SLC_B_FWD_CE_HI:`SLC_B_FWD_CE_LO] = fwd_reg[s.idx].chanend;
			end
			default: w = 32'h00000000;
		endcase
		return w;
	endfunction
	// write address and data are taken in either order, then committed together
	assign s_axi_awready = !aw_held;
	assign s_axi_wready  = !w_held;
	assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
	assign wsel          = slc_decode(awaddr_q);
	assign wmask         = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	// always_comb also wakes on the registers that slc_word reads
	always_comb wd = (slc_word(wsel) & ~wmask) | (wdata_q & wmask);
	assign wr_ok         = wr_fire && !protect;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held  <= 1'b0;
			awaddr_q <= 12'h000;
		end else if (s_axi_awvalid && !aw_held) begin
			aw_held  <= 1'b1;
			awaddr_q <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held  <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held  <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && !w_held) begin
			w_held  <= 1'b1;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held  <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SLC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wsel.region == SLC_R_NONE) ? `SLC_RESP_DECERR : `SLC_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			protect  <= 1'b0;
			hdr_mode <= 1'b0;
			node_id  <= `SLC_RST_NODE;
			dir_lo   <= `SLC_RST_DIRS;
			dir_hi   <= `SLC_RST_DIRS;
		end else if (wr_ok) begin
			case (wsel.region)
				SLC_R_SWCFG: begin
					protect  <= wd[`SLC_B_PROTECT];
					hdr_mode <= wd[`SLC_B_HDR_MODE];
				end
				SLC_R_NODE:  node_id <= wd[15:0];
				SLC_R_DIRLO: dir_lo <= wd;
				SLC_R_DIRHI: dir_hi <= wd;
				default: ;
			endcase
		end
	end
	generate
		for (genvar gi = 0; gi < 8; gi++) begin : g_link
			logic hit_lstat, hit_pstat, hit_lcfg, hit_static;
			assign hit_lstat  = wr_ok && wsel.region == SLC_R_LSTAT && wsel.idx == 3'(gi);
			assign hit_pstat  = wr_ok && wsel.region == SLC_R_PSTAT && wsel.idx == 3'(gi);
			assign hit_lcfg   = wr_ok && wsel.region == SLC_R_LCFG && wsel.idx == 3'(gi);
			assign hit_static = wr_ok && wsel.region == SLC_R_STATIC && wsel.idx == 3'(gi);
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					lnk_dir[gi] <= `SLC_RST_DIR;
					lnk_net[gi] <= `SLC_RST_NET;
				end else if (hit_lstat) begin
					lnk_dir[gi] <= wd[`SLC_B_DIR_HI:`SLC_B_DIR_LO];
					lnk_net[gi] <= wd[`SLC_B_NET_HI:`SLC_B_NET_LO];
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					plnk_net[gi] <= `SLC_RST_NET;
				end else if (hit_pstat) begin
					plnk_net[gi] <= wd[`SLC_B_NET_HI:`SLC_B_NET_LO];
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					lnk_en[gi]   <= 1'b0;
					lnk_five[gi] <= 1'b0;
					sym_gap[gi]  <= `SLC_RST_GAP;
					tok_gap[gi]  <= `SLC_RST_GAP;
				end else if (hit_lcfg) begin
					lnk_en[gi]   <= wd[`SLC_B_ENABLE];
					lnk_five[gi] <= wd[`SLC_B_FIVE_WIRE];
					sym_gap[gi]  <= wd[`SLC_B_SGAP_HI:`SLC_B_SGAP_LO];
					tok_gap[gi]  <= wd[`SLC_B_TGAP_HI:`SLC_B_TGAP_LO];
				end
			end
			// write-only strobes become one-cycle pulses toward the link
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					credit_greeting_token_strobe[gi] <= 1'b0;
					rx_restart[gi]   <= 1'b0;
				end else begin
					credit_greeting_token_strobe[gi] <= hit_lcfg && wstrb_q[3] && wdata_q[`SLC_B_CREDIT_GREETING_TOKEN];
					rx_restart[gi]   <= hit_lcfg && wstrb_q[2] && wdata_q[`SLC_B_RX_RESTART];
				end
			end
			// fault is sticky until the receiver is restarted; a new fault wins
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					rx_fault[gi] <= 1'b0;
				end else if (phy_state[gi].rx_fault) begin
					rx_fault[gi] <= 1'b1;
				end else if (rx_restart[gi]) begin
					rx_fault[gi] <= 1'b0;
				end
			end
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					fwd_reg[gi] <= `SLC_RST_FWD;
				end else if (hit_static) begin
					fwd_reg[gi].enable  <= wd[`SLC_B_FWD_EN];
					fwd_reg[gi].proc    <= wd[`SLC_B_FWD_PROC];
					fwd_reg[gi].chanend <= wd[`SLC_B_FWD_CE_HI:`SLC_B_FWD_CE_LO];
				end
			end
			assign lnk_ctrl[gi].enable    = lnk_en[gi];
			assign lnk_ctrl[gi].five_wire = lnk_five[gi];
			assign lnk_ctrl[gi].direction = lnk_dir[gi];
			assign lnk_ctrl[gi].network   = lnk_net[gi];
			assign plnk_network[gi]       = plnk_net[gi];
			// register order c,d,a,b,g,h,e,f: letter index is register index with bit 1 flipped
			assign fwd_cfg[gi]            = fwd_reg[gi ^ 2];
			slc_link_pacer u_pacer (
				.aclk      (aclk),
				.aresetn   (aresetn),
				.sym_gap   (sym_gap[gi]),
				.tok_gap   (tok_gap[gi]),
				.sym_valid (tx_sym_valid[gi]),
				.sym_last  (tx_sym_last[gi]),
				.sym_ready (tx_sym_ready[gi])
			);
		end
	endgenerate
	// read channel: one outstanding read, data from a register
	assign s_axi_arready = !s_axi_rvalid;
	assign rsel          = slc_decode(s_axi_araddr);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= `SLC_RESP_OKAY;
			rd_region    <= SLC_R_NONE;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= slc_word(rsel);
			s_axi_rresp  <= (rsel.region == SLC_R_NONE) ? `SLC_RESP_DECERR : `SLC_RESP_OKAY;
			rd_region    <= rsel.region;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	// routing lookup on the most significant mismatching node bit
	logic [15:0]      route_diff;
	logic [3:0]       route_bit;
	logic [15:0][3:0] dir_table;
	assign route_diff = route_node_id ^ node_id;
	assign dir_table  = {dir_hi, dir_lo};
	always_comb begin
		route_bit = 4'h0;
		for (int j = 0; j < 16; j++) begin
			if (route_diff[j]) begin
				route_bit = 4'(j);
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			route_dir   <= 4'h0;
			route_local <= 1'b0;
		end else begin
			route_dir   <= dir_table[route_bit];
			route_local <= (route_diff == 16'h0000);
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_protect_blocks_write: assert property (wr_fire && protect |=> $stable(lnk_en) && $stable(sym_gap) && protect)
		else $error("write changed registers while protected");
	a_credit_greeting_token_one_pulse: assert property (wr_ok && wsel.region == SLC_R_LCFG && wstrb_q[3] && wdata_q[`SLC_B_CREDIT_GREETING_TOKEN]
		|=> credit_greeting_token_strobe != 8'h00 ##1 credit_greeting_token_strobe == 8'h00)
		else $error("credit_greeting_token strobe not a single pulse");
	a_restart_pulse: assert property (wr_ok && wsel.region == SLC_R_LCFG && wstrb_q[2] && wdata_q[`SLC_B_RX_RESTART]
		|=> rx_restart != 8'h00)
		else $error("receiver restart not pulsed");
	a_fault_sticky: assert property (phy_state[1].rx_fault |=> rx_fault[1] ##1 (rx_fault[1] || $past(rx_restart[1])))
		else $error("receive fault flag lost");
	a_processor_side_link_reserved_zero: assert property (s_axi_rvalid && rd_region == SLC_R_PSTAT
		|-> s_axi_rdata[15:6] == 10'h000 && s_axi_rdata[31:26] == 6'h00)
		else $error("processor link status reserved bits not zero");
	a_write_response: assert property (wr_fire |=> s_axi_bvalid)
		else $error("write not answered");
	a_route_local_dir: assert property (route_node_id == node_id && $stable(node_id) |=> route_local)
		else $error("matching node id not seen as local");
	a_static_order: assert property (wr_ok && wsel.region == SLC_R_STATIC && wsel.idx == 3'h0
		|=> fwd_cfg[2].enable == $past(wd[`SLC_B_FWD_EN]) && fwd_cfg[2].proc == $past(wd[`SLC_B_FWD_PROC])
			&& fwd_cfg[2].chanend == $past(wd[`SLC_B_FWD_CE_HI:`SLC_B_FWD_CE_LO]))
		else $error("static register order broken");
	c_credit_greeting_token_sent: cover property (credit_greeting_token_strobe != 8'h00);
	c_static_on: cover property (fwd_cfg[0].enable);
	c_read_done: cover property (s_axi_rvalid && s_axi_rready);
	c_protected: cover property (protect);
endmodule // slc_switch_link_regs

// File: test/slc_remote_model.sv
// far-end switch model: credit exchange and receive fault events
`timescale 1ns/1ps
module slc_remote_model
	import slc_pkg::*;
(
	// clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	// local link controls
	input  wire slc_lnk_ctrl_t [7:0] lnk_ctrl,
	input  wire logic [7:0]          credit_greeting_token_strobe,
	// fault injection from the bench
	input  wire logic [7:0]          fault_req,
	output slc_phy_state_t [7:0]     phy_state
);
	logic [7:0] en_d;
	always_ff @(posedge aclk) begin
		for (int i = 0; i < 8; i++) begin
			en_d[i] <= aresetn & lnk_ctrl[i].enable;
			phy_state[i].credit_given <= aresetn & lnk_ctrl[i].enable;
			phy_state[i].rx_fault <= aresetn & fault_req[i];
			if (!aresetn || credit_greeting_token_strobe[i])
				phy_state[i].credit_held <= 1'b0;
			else if (lnk_ctrl[i].enable && !en_d[i])
				phy_state[i].credit_held <= 1'b1;
		end
	end
endmodule // slc_remote_model

// File: test/switch_link_config_status_tb_top.sv
// self-checking bench of the switch link register block
`timescale 1ns/1ps
`include "slc_defs.svh"
module switch_link_config_status_tb_top;
	import slc_pkg::*;
	logic                 aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, route_local;
	logic [11:0]          s_axi_awaddr, s_axi_araddr;
	logic [31:0]          s_axi_wdata, s_axi_rdata, w, d;
	logic [3:0]           s_axi_wstrb, route_dir;
	logic [1:0]           s_axi_bresp, s_axi_rresp;
	slc_lnk_state_t [7:0] lnk_state, plnk_state;
	slc_phy_state_t [7:0] phy_state;
	slc_lnk_ctrl_t [7:0]  lnk_ctrl;
	slc_fwd_t [7:0]       fwd_cfg;
	logic [7:0][1:0]      plnk_network;
	logic [7:0]           credit_greeting_token_strobe, rx_restart, tx_sym_valid, tx_sym_last, tx_sym_ready, fault_req;
	logic [15:0]          route_node_id, nd, x;
	logic [127:0]         r;
	logic [63:0]          dd;
	int                   n_mismatch, tests_run, g, m, dir_m[8], net_m[8];

	slc_switch_link_regs i_slc_switch_link_regs (.*);
	slc_remote_model     i_slc_remote_model (.*);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		tests_run++;
		if (v !== e) begin
			$display("Error %s expected %h seen %h", nm, e, v);
			n_mismatch++;
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic logic [11:0] ad(input logic [7:0] idx, input int i);
		return {2'b00, idx + 8'(i), 2'b00};
	endfunction

	function automatic logic [31:0] stat(input slc_lnk_state_t s, input int dr, input int nt);
		return {6'h00, s.stype, s.dest, 4'h0, 4'(dr), 2'h0, 2'(nt), 1'b0, s.junk, s.dest_busy, s.src_busy};
	endfunction

	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
		logic       ta, tw, tb;
		logic [1:0] rs;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			#1;
			ta = s_axi_awready & s_axi_awvalid;
			tw = s_axi_wready & s_axi_wvalid;
			tb = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) begin
				chk("bresp", 32'(e), 32'(rs));
				return;
			end
		end
		n_mismatch++;
		print_verdict();
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] v, input logic [1:0] e);
		logic       ta, tr;
		logic [1:0] rs;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			#1;
			ta = s_axi_arready & s_axi_arvalid;
			tr = s_axi_rvalid;
			v = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) begin
				chk("rresp", 32'(e), 32'(rs));
				return;
			end
		end
		n_mismatch++;
		print_verdict();
	endtask

	// fires with valid held high; spacing between the first two fires
	task automatic pace(input logic last, input int e);
		int q[$];
		tx_sym_last[0] <= last;
		tx_sym_valid[0] <= 1'b1;
		for (int n = 0; n < 40; n++) begin
			#1;
			if (tx_sym_ready[0]) q.push_back(n);
			@(posedge aclk);
		end
		tx_sym_valid[0] <= 1'b0;
		repeat (30) @(posedge aclk);
		chk("pace", 32'(e), 32'(q[1] - q[0]));
	endtask

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		{lnk_state, plnk_state, tx_sym_valid, tx_sym_last, fault_req, route_node_id} = '0;
		aresetn = 1'b0;
		void'($urandom(85));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			rd(ad(`SLC_IDX_LCFG, i), d, `SLC_RESP_OKAY);
			chk("lcfg_rst", 32'h0, d);
			rd(ad(`SLC_IDX_STATIC, i), d, `SLC_RESP_OKAY);
			chk("static_rst", 32'h0, d);
		end
		$display("reset test done");
		r = {$urandom, $urandom, $urandom, $urandom};
		lnk_state <= r[103:0];
		plnk_state <= r[127:24];
		for (int i = 0; i < 8; i++) begin
			w = $urandom;
			dir_m[i] = int'(w[11:8]);
			net_m[i] = int'(w[5:4]);
			wr(ad(`SLC_IDX_LSTAT, i), w, `SLC_RESP_OKAY);
			rd(ad(`SLC_IDX_LSTAT, i), d, `SLC_RESP_OKAY);
			chk("lstat", stat(lnk_state[i], dir_m[i], net_m[i]), d);
			chk("lnk_dir", 32'(dir_m[i]), 32'(lnk_ctrl[i].direction));
			chk("lnk_net", 32'(net_m[i]), 32'(lnk_ctrl[i].network));
			wr(ad(`SLC_IDX_PSTAT, i), ~w, `SLC_RESP_OKAY);
			rd(ad(`SLC_IDX_PSTAT, i), d, `SLC_RESP_OKAY);
			chk("pstat", stat(plnk_state[i], 0, 3 - net_m[i]), d);
			chk("plnk_net", 32'(3 - net_m[i]), 32'(plnk_network[i]));
		end
		$display("status test done");
		wr(ad(`SLC_IDX_LCFG, 1), 32'hb040_0000, `SLC_RESP_OKAY);
		repeat (2) @(posedge aclk);
		rd(ad(`SLC_IDX_LCFG, 1), d, `SLC_RESP_OKAY);
		chk("lcfg_en", 32'h8600_0000, d);
		chk("link_en", 32'h1, 32'(lnk_ctrl[1].enable));
		wr(ad(`SLC_IDX_LCFG, 1), 32'hc100_0000, `SLC_RESP_OKAY);
		repeat (2) @(posedge aclk);
		rd(ad(`SLC_IDX_LCFG, 1), d, `SLC_RESP_OKAY);
		chk("credit_greeting_token", 32'hc400_0000, d);
		chk("five_wire", 32'h1, 32'(lnk_ctrl[1].five_wire));
		fault_req[1] <= 1'b1;
		@(posedge aclk);
		fault_req[1] <= 1'b0;
		repeat (3) @(posedge aclk);
		rd(ad(`SLC_IDX_LCFG, 1), d, `SLC_RESP_OKAY);
		chk("rx_fault", 32'hcc00_0000, d);
		wr(ad(`SLC_IDX_LCFG, 1), 32'hc080_0000, `SLC_RESP_OKAY);
		rd(ad(`SLC_IDX_LCFG, 1), d, `SLC_RESP_OKAY);
		chk("rx_restart", 32'hc400_0000, d);
		$display("link config test done");
		g = $urandom_range(0, 20);
		wr(ad(`SLC_IDX_LCFG, 0), {10'h200, 11'(g), 11'd2}, `SLC_RESP_OKAY);
		pace(1'b0, g + 2);
		pace(1'b1, 4);
		wr(ad(`SLC_IDX_LCFG, 0), {10'h200, 11'd0, 11'd2}, `SLC_RESP_OKAY);
		pace(1'b0, 2);
		$display("pacing test done");
		for (int i = 0; i < 8; i++) begin
			w = $urandom;
			wr(ad(`SLC_IDX_STATIC, i), w, `SLC_RESP_OKAY);
			rd(ad(`SLC_IDX_STATIC, i), d, `SLC_RESP_OKAY);
			chk("static", w & 32'h8000_011f, d);
			chk("fwd", 32'({w[31], w[8], w[4:0]}), 32'(fwd_cfg[i ^ 2]));
		end
		$display("static test done");
		nd = 16'($urandom);
		dd = {$urandom, $urandom};
		wr(ad(`SLC_IDX_NODE, 0), 32'(nd), `SLC_RESP_OKAY);
		wr(ad(`SLC_IDX_DIR_LO, 0), dd[31:0], `SLC_RESP_OKAY);
		wr(ad(`SLC_IDX_DIR_HI, 0), dd[63:32], `SLC_RESP_OKAY);
		for (int k = 0; k < 8; k++) begin
			x = (k == 0) ? 16'h0 : 16'($urandom_range(1, 65535));
			m = 0;
			for (int b = 0; b < 16; b++)
				if (x[b]) m = b;
			route_node_id <= nd ^ x;
			@(posedge aclk);
			#1;
			chk("route", {x == 0, 4'(dd >> (4 * m))}, {route_local, route_dir});
			@(posedge aclk);
		end
		wr(12'hc00, 32'hffff_ffff, `SLC_RESP_DECERR);
		rd(12'hc00, d, `SLC_RESP_DECERR);
		chk("unmapped", 32'h0, d);
		wr(ad(`SLC_IDX_SWCFG, 0), 32'h8000_0000, `SLC_RESP_OKAY);
		wr(ad(`SLC_IDX_LSTAT, 0), ~stat(lnk_state[0], dir_m[0], net_m[0]), `SLC_RESP_OKAY);
		rd(ad(`SLC_IDX_LSTAT, 0), d, `SLC_RESP_OKAY);
		chk("protect", stat(lnk_state[0], dir_m[0], net_m[0]), d);
		$display("bus test done");
		print_verdict();
	end
endmodule // switch_link_config_status_tb_top
